/* File: logic/adc_seq_pkg.sv */
// Purpose: shared constants for the converter channel sequencer
// Assumes: 25 MHz reference clock, all other rates derived from it
// Notes:   rates in Hz, times in ms, cycle counts derived below
package adc_seq_pkg;
    localparam int unsigned REF_CLK_HZ  = 25_000_000;
    localparam int unsigned CORE_CLK_HZ = 1_330_000;
    // rounded to nearest: the core rate is only approximate anyway
    localparam int unsigned CORE_DIV    = (REF_CLK_HZ + CORE_CLK_HZ / 2) / CORE_CLK_HZ;
    localparam int unsigned FAST_CLK_HZ = 2_000_000;
    localparam int unsigned SLOW_HZ     = 32_768;
    localparam int unsigned ACC_W       = 32;

    localparam int unsigned CODE_W      = 5;
    localparam int unsigned RESULT_W    = 10;
    localparam int unsigned ENTRIES     = 32;
    localparam int unsigned IDX_W       = 5;
    localparam int unsigned SLEEP_W     = 3;

    localparam logic [4:0] STOP_CODE    = 5'h1f;
    localparam logic [4:0] LAST_DEFINED = 5'h15;
    localparam logic [4:0] TOUCH_FIRST  = 5'h0a;
    localparam logic [4:0] TOUCH_LAST   = 5'h0d;
    localparam logic [4:0] GP_FIRST     = 5'h0a;
    localparam logic [4:0] OPT_SUPPLY   = 5'h16;
    localparam logic [4:0] OPT_CHARGE   = 5'h18;
    localparam logic [4:0] OPT_BACKUP   = 5'h19;
    localparam logic [4:0] OPT_BATDET   = 5'h1a;

    localparam int unsigned SLEEP_MAX_MS  = 27;
    localparam int unsigned SLEEP_STEPS   = 7;
    // longest interval rounds down, so code 7 never exceeds 27 ms
    localparam int unsigned SLEEP_STEP_TICKS = (SLEEP_MAX_MS * SLOW_HZ)
                                             / (1000 * SLEEP_STEPS);
    localparam int unsigned SLEEP_CNT_W   = 10;

    localparam logic [3:0] OPT_RESET      = 4'h0;
    localparam logic [4:0] CODE_RESET     = 5'h1f;
endpackage : adc_seq_pkg

/* File: logic/tick_if.sv */
// Purpose: carries the derived time-base strobes between modules
// Assumes: one clock domain, strobes are one-cycle pulses
// Notes:   src drives, dst observes
interface tick_if;
    logic core_tick;
    logic fast_tick;
    logic slow_tick;
    modport src (output core_tick, output fast_tick, output slow_tick);
    modport dst (input  core_tick, input  fast_tick, input  slow_tick);
endinterface : tick_if

/* File: logic/adc_timebase.sv */
// Purpose: derives core, 2.0 MHz and 32.768 kHz strobes from the reference clock
// Assumes: ref_clk_i at REF_CLK_HZ
// Notes:   2.0 MHz and 32.768 kHz use accumulators, so 2.0 MHz jitters by one cycle, 32.768 kHz by one 2.0 MHz period; core uses a rounded divider
module adc_timebase
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    tick_if.src       tb
);
    logic [7:0]  core_cnt_reg;
    logic [31:0] fast_acc_reg;
    logic [31:0] slow_acc_reg;
    logic        core_tick_reg;
    logic        fast_tick_reg;
    logic        slow_tick_reg;

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            core_cnt_reg  <= 8'h00;
            core_tick_reg <= 1'b0;
        end
        else if (core_cnt_reg == 8'(adc_seq_pkg::CORE_DIV - 1))
        begin
            core_cnt_reg  <= 8'h00;
            core_tick_reg <= 1'b1;
        end
        else
        begin
            core_cnt_reg  <= core_cnt_reg + 8'h01;
            core_tick_reg <= 1'b0;
        end
    end

    // 2.0 MHz strobe from the reference, then 32.768 kHz from that strobe
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fast_acc_reg  <= 32'h0;
            fast_tick_reg <= 1'b0;
        end
        else if (fast_acc_reg + adc_seq_pkg::FAST_CLK_HZ >= adc_seq_pkg::REF_CLK_HZ)
        begin
            fast_acc_reg  <= fast_acc_reg + adc_seq_pkg::FAST_CLK_HZ
                           - adc_seq_pkg::REF_CLK_HZ;
            fast_tick_reg <= 1'b1;
        end
        else
        begin
            fast_acc_reg  <= fast_acc_reg + adc_seq_pkg::FAST_CLK_HZ;
            fast_tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            slow_acc_reg  <= 32'h0;
            slow_tick_reg <= 1'b0;
        end
        else if (!fast_tick_reg)
            slow_tick_reg <= 1'b0;
        else if (slow_acc_reg + adc_seq_pkg::SLOW_HZ >= adc_seq_pkg::FAST_CLK_HZ)
        begin
            slow_acc_reg  <= slow_acc_reg + adc_seq_pkg::SLOW_HZ
                           - adc_seq_pkg::FAST_CLK_HZ;
            slow_tick_reg <= 1'b1;
        end
        else
        begin
            slow_acc_reg  <= slow_acc_reg + adc_seq_pkg::SLOW_HZ;
            slow_tick_reg <= 1'b0;
        end
    end

    assign tb.core_tick = core_tick_reg;
    assign tb.fast_tick = fast_tick_reg;
    assign tb.slow_tick = slow_tick_reg;

    slow_from_fast_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        slow_tick_reg |-> $past(fast_tick_reg))
        else $error("slow strobe without a 2.0 MHz strobe");
endmodule : adc_timebase

/* File: logic/adc_channel_sequencer.sv */
// Purpose: walks the selection table, converts each channel, stores results
// Assumes: analog front end answers conv_done_i after conv_start_o
// Notes:   control and status are plain ports, no register bus
module adc_channel_sequencer
(
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        converter_enable_bit_i,
    input  wire logic        sequence_start_bit_i,
    input  wire logic [2:0]  loop_sleep_interval_i,
    input  wire logic [3:0]  optional_activate_i,
    input  wire logic        touch_mode_i,
    input  wire logic        gain_high_i,
    input  wire logic        irq_mask_i,
    input  wire logic        round_clear_i,
    input  wire logic        source_clear_i,
    input  wire logic        table_write_i,
    input  wire logic [4:0]  table_addr_i,
    input  wire logic [4:0]  selection_table_entry_i,
    input  wire logic [4:0]  result_addr_i,
    output logic      [10:0] result_data_o,
    input  wire logic        pll_active_i,
    output logic             pll_request_o,
    output logic             conv_start_o,
    output logic      [4:0]  channel_code_field_o,
    output logic             channel_defined_o,
    output logic             touch_select_o,
    output logic             gain_select_o,
    input  wire logic        conv_done_i,
    input  wire logic [9:0]  conv_result_i,
    output logic             busy_o,
    output logic             round_complete_flag_o,
    output logic             adc_source_bit_o,
    output logic             external_interrupt_output_o
);
    typedef enum logic [2:0] {IDLE, PLL_WAIT, SELECT, CONVERT, SLEEP} seq_state_t;

    tick_if tb ();
    adc_timebase u_timebase
    (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .tb        (tb)
    );

    logic [4:0]  table_mem [adc_seq_pkg::ENTRIES];
    logic [10:0] result_mem [adc_seq_pkg::ENTRIES];
    seq_state_t  state_reg;
    logic [4:0]  idx_reg;
    logic [9:0]  sleep_cnt_reg;
    logic        gain_reg;
    logic        round_done_pulse;
    logic        run;
    logic [4:0]  entry;
    logic        defined;

    assign run   = converter_enable_bit_i && sequence_start_bit_i;
    assign entry = table_mem[idx_reg];

    // optional codes need their activation bit, everything above 21 else reserved
    always_comb
    begin
        case (entry)
            adc_seq_pkg::OPT_SUPPLY: defined = optional_activate_i[0];
            adc_seq_pkg::OPT_CHARGE: defined = optional_activate_i[1];
            adc_seq_pkg::OPT_BACKUP: defined = optional_activate_i[2];
            adc_seq_pkg::OPT_BATDET: defined = optional_activate_i[3];
            default:                 defined = (entry <= adc_seq_pkg::LAST_DEFINED);
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (table_write_i)
            table_mem[table_addr_i] <= selection_table_entry_i;
    end

    // results overwrite in place each loop; no read-side protection
    always_ff @(posedge ref_clk_i)
    begin
        if (state_reg == CONVERT && conv_done_i)
            result_mem[idx_reg] <= {gain_reg, conv_result_i};
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            result_data_o <= 11'h000;
        else
            result_data_o <= result_mem[result_addr_i];
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg        <= IDLE;
            idx_reg          <= 5'h00;
            sleep_cnt_reg    <= 10'h000;
            round_done_pulse <= 1'b0;
        end
        else
        begin
            round_done_pulse <= 1'b0;
            if (!run)
                state_reg <= IDLE;
            else
            begin
                case (state_reg)
                    IDLE:
                    begin
                        idx_reg   <= 5'h00;
                        state_reg <= pll_active_i ? SELECT : PLL_WAIT;
                    end
                    PLL_WAIT:
                        if (pll_active_i)
                            state_reg <= SELECT;
                    SELECT:
                        if (tb.core_tick)
                        begin
                            if (entry == adc_seq_pkg::STOP_CODE)
                            begin
                                round_done_pulse <= 1'b1;
                                sleep_cnt_reg    <= 10'(loop_sleep_interval_i
                                                   * adc_seq_pkg::SLEEP_STEP_TICKS);
                                state_reg        <= SLEEP;
                            end
                            else
                                state_reg <= CONVERT;
                        end
                    CONVERT:
                        if (conv_done_i)
                        begin
                            idx_reg <= idx_reg + 5'h01;
                            // a full table without a stop code still closes the round
                            if (idx_reg == 5'(adc_seq_pkg::ENTRIES - 1))
                            begin
                                round_done_pulse <= 1'b1;
                                sleep_cnt_reg    <= 10'(loop_sleep_interval_i
                                                   * adc_seq_pkg::SLEEP_STEP_TICKS);
                                state_reg        <= SLEEP;
                            end
                            else
                                state_reg <= SELECT;
                        end
                    SLEEP:
                        if (sleep_cnt_reg == 10'h000)
                        begin
                            idx_reg   <= 5'h00;
                            state_reg <= pll_active_i ? SELECT : PLL_WAIT;
                        end
                        else if (tb.slow_tick)
                            sleep_cnt_reg <= sleep_cnt_reg - 10'h001;
                    default:
                        state_reg <= IDLE;
                endcase
            end
        end
    end

    // front-end controls, all registered
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            conv_start_o         <= 1'b0;
            channel_code_field_o <= adc_seq_pkg::CODE_RESET;
            channel_defined_o    <= 1'b0;
            touch_select_o       <= 1'b0;
            gain_select_o        <= 1'b0;
            gain_reg             <= 1'b0;
        end
        else
        begin
            conv_start_o <= run && state_reg == SELECT && tb.core_tick
                            && entry != adc_seq_pkg::STOP_CODE;
            if (run && state_reg == SELECT && tb.core_tick
                && entry != adc_seq_pkg::STOP_CODE)
            begin
                channel_code_field_o <= entry;
                channel_defined_o    <= defined;
                touch_select_o       <= touch_mode_i && entry >= adc_seq_pkg::TOUCH_FIRST
                                        && entry <= adc_seq_pkg::TOUCH_LAST;
                // gain bit only has meaning on general-purpose inputs
                gain_select_o        <= gain_high_i && entry >= adc_seq_pkg::GP_FIRST
                                        && entry <= adc_seq_pkg::LAST_DEFINED
                                        && !(touch_mode_i && entry <= adc_seq_pkg::TOUCH_LAST);
                gain_reg             <= gain_high_i && entry >= adc_seq_pkg::GP_FIRST
                                        && entry <= adc_seq_pkg::LAST_DEFINED
                                        && !(touch_mode_i && entry <= adc_seq_pkg::TOUCH_LAST);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pll_request_o <= 1'b0;
            busy_o        <= 1'b0;
        end
        else
        begin
            // hold the request for the whole run so the PLL stays up
            pll_request_o <= run;
            busy_o        <= run && state_reg != IDLE;
        end
    end

    // set wins over clear for both sticky bits
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            round_complete_flag_o       <= 1'b0;
            adc_source_bit_o            <= 1'b0;
            external_interrupt_output_o <= 1'b0;
        end
        else
        begin
            if (round_done_pulse)
                round_complete_flag_o <= 1'b1;
            else if (round_clear_i)
                round_complete_flag_o <= 1'b0;
            if (round_done_pulse)
                adc_source_bit_o <= 1'b1;
            else if (source_clear_i)
                adc_source_bit_o <= 1'b0;
            external_interrupt_output_o <= (round_done_pulse || (adc_source_bit_o
                                           && !source_clear_i)) && !irq_mask_i;
        end
    end

    sequence stop_seen_s;
        run && state_reg == SELECT && tb.core_tick && entry == adc_seq_pkg::STOP_CODE;
    endsequence
    sequence flag_up_s;
        round_complete_flag_o && adc_source_bit_o;
    endsequence

    stop_sets_flags_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        stop_seen_s |=> ##1 flag_up_s)
        else $error("stop code did not raise the round and source bits");
    irq_mask_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        external_interrupt_output_o |-> adc_source_bit_o && !$past(irq_mask_i))
        else $error("interrupt output while masked or without source");
    pll_request_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        state_reg == PLL_WAIT |-> ##1 pll_request_o || !run)
        else $error("waiting for the PLL without requesting it");
    pll_before_conv_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        conv_start_o |-> pll_request_o && $past(state_reg) == SELECT)
        else $error("conversion started while waiting for the PLL");
    core_pace_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        conv_start_o |-> $past(tb.core_tick))
        else $error("conversion start off the core strobe");
    reserved_code_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        conv_start_o && channel_code_field_o > adc_seq_pkg::OPT_BATDET
        |-> !channel_defined_o)
        else $error("reserved code marked as defined");
    optional_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        conv_start_o && channel_code_field_o == adc_seq_pkg::OPT_SUPPLY
        |-> channel_defined_o == $past(optional_activate_i[0]))
        else $error("optional channel defined against its activation bit");
    stop_no_conv_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        stop_seen_s |=> !conv_start_o && state_reg == SLEEP)
        else $error("stop code started a conversion");
    sleep_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        state_reg == SLEEP && sleep_cnt_reg != 10'h000 && run |=> state_reg == SLEEP)
        else $error("sleep ended before its interval");
    touch_gain_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        touch_select_o |-> !gain_select_o)
        else $error("gain selected on a touch electrode");
endmodule : adc_channel_sequencer

/* File: tb/adc_front_end_model.sv */
// Purpose: behavioural analog front end answering conversion requests
// Assumes: one request outstanding at a time, taken on conv_start_i
// Notes:   result only valid with conv_done_o; it toggles while idle and holds while a request is pending
module adc_front_end_model
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       conv_start_i,
    input  wire logic [4:0] code_i,
    input  wire logic       slow_i,
    output logic            conv_done_o,
    output logic [9:0]      conv_result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    logic       pend_reg;
    logic [4:0] code_reg;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pend_reg      <= 1'b0;
            wait_reg      <= 4'h0;
            code_reg      <= 5'h00;
            conv_done_o   <= 1'b0;
            conv_result_o <= 10'h2aa;
        end
        else
        begin
            conv_done_o <= 1'b0;
            if (conv_start_i)
            begin
                pend_reg <= 1'b1;
                code_reg <= code_i;
                wait_reg <= slow_i ? 4'hc : 4'h2;
            end
            else if (pend_reg && wait_reg == 4'h0)
            begin
                pend_reg      <= 1'b0;
                conv_done_o   <= 1'b1;
                conv_result_o <= {code_reg, ~code_reg};
            end
            else if (pend_reg)
                wait_reg <= wait_reg - 4'h1;
            else
                conv_result_o <= ~conv_result_o; // no stale value between results
        end
    end
endmodule : adc_front_end_model

/* File: tb/test_adc_channel_sequencer.sv */
// Purpose: self-checking bench for the converter channel sequencer
// Assumes: designer latencies; core strobe every 19 reference cycles
// Notes:   sleep code 0 so rounds repeat; one late round sleeps on code 1
module test_adc_channel_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [4:0] code; logic def; logic tch; logic gn; } row_t;
    localparam int N = 9;
    row_t rows [N] = '{ {5'h00,3'b100}, {5'h09,3'b100}, {5'h0a,3'b110}, {5'h0e,3'b101},
                        {5'h15,3'b101}, {5'h16,3'b100}, {5'h17,3'b000}, {5'h1a,3'b000},
                        {5'h1f,3'b000} };
    logic        ref_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        enable = 1'b0, start = 1'b0, touch = 1'b1, gain_hi = 1'b1, mask = 1'b0;
    logic        rclr = 1'b0, sclr = 1'b0, twr = 1'b0, pll_on = 1'b0, slow = 1'b0;
    logic [4:0]  taddr = 5'h00, tentry = 5'h00, raddr = 5'h00;
    logic [2:0]  sleep = 3'h0;
    logic [10:0] rdata;
    logic        pll_req, cstart, cdef, ctouch, cgain, cdone, busy, rnd, src, irq;
    logic [4:0]  ccode;
    logic [9:0]  cres;
    int          fails = 0, checks_done = 0, starts_seen = 0, i;

    initial forever #20 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i) if (cstart === 1'b1) starts_seen++;

    adc_channel_sequencer DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .converter_enable_bit_i(enable), .sequence_start_bit_i(start),
        .loop_sleep_interval_i(sleep), .optional_activate_i(4'h1), .touch_mode_i(touch),
        .gain_high_i(gain_hi), .irq_mask_i(mask), .round_clear_i(rclr), .source_clear_i(sclr),
        .table_write_i(twr), .table_addr_i(taddr), .selection_table_entry_i(tentry),
        .result_addr_i(raddr), .result_data_o(rdata), .pll_active_i(pll_on),
        .pll_request_o(pll_req), .conv_start_o(cstart), .channel_code_field_o(ccode),
        .channel_defined_o(cdef), .touch_select_o(ctouch), .gain_select_o(cgain),
        .conv_done_i(cdone), .conv_result_i(cres), .busy_o(busy),
        .round_complete_flag_o(rnd), .adc_source_bit_o(src),
        .external_interrupt_output_o(irq));

    adc_front_end_model front (.clk_i(ref_clk_i), .resetn_i(resetn_i), .conv_start_i(cstart),
        .code_i(ccode), .slow_i(slow), .conv_done_o(cdone), .conv_result_o(cres));

    task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    // which: 0 conversion start, 1 round flag
    task automatic wait_hi(input int which, input int bound);
        int n;
        for (n = 0; n < bound; n++)
        begin
            @(negedge ref_clk_i);
            if ((which == 0 && cstart === 1'b1) || (which == 1 && rnd === 1'b1))
                return;
        end
        fails++;
        $display("unexpected timeout waiting on %0d", which);
        final_report();
    endtask : wait_hi

    initial
    begin
        repeat (5) @(negedge ref_clk_i);
        check("code in reset", {6'h00, ccode}, {6'h00, 5'h1f});
        check("busy in reset", {10'h000, busy}, 11'h000);
        @(posedge ref_clk_i) resetn_i <= 1'b1;
        for (i = 0; i < N; i++)
        begin
            @(posedge ref_clk_i);
            twr    <= 1'b1;
            taddr  <= 5'(i);
            tentry <= rows[i].code;
        end
        @(posedge ref_clk_i) twr <= 1'b0;
        enable <= 1'b1;
        start  <= 1'b1;
        repeat (100) @(negedge ref_clk_i);
        check("pll request", {10'h000, pll_req}, 11'h001);
        check("starts without pll", 11'(starts_seen), 11'h000);
        @(posedge ref_clk_i) pll_on <= 1'b1;
        for (i = 0; i < N - 1; i++)
        begin
            wait_hi(0, 200);
            check("code", {6'h00, ccode}, {6'h00, rows[i].code});
            check("defined", {10'h000, cdef}, {10'h000, rows[i].def});
            check("touch", {10'h000, ctouch}, {10'h000, rows[i].tch});
            check("gain", {10'h000, cgain}, {10'h000, rows[i].gn});
        end
        wait_hi(1, 400);
        check("source", {10'h000, src}, 11'h001);
        check("irq", {10'h000, irq}, 11'h001);
        check("starts per round", 11'(starts_seen), 11'(N - 1));
        for (i = 0; i < N - 1; i++)
        begin
            @(posedge ref_clk_i) raddr <= 5'(i);
            @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            if (rows[i].def)
                check("result", rdata, {rows[i].gn, rows[i].code, ~rows[i].code});
        end
        @(posedge ref_clk_i);
        mask <= 1'b1;
        rclr <= 1'b1;
        sclr <= 1'b1;
        slow <= 1'b1;
        @(posedge ref_clk_i);
        rclr <= 1'b0;
        sclr <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check("irq masked", {10'h000, irq}, 11'h000);
        wait_hi(1, 4000);
        check("source again", {10'h000, src}, 11'h001);
        @(negedge ref_clk_i);
        check("irq stays masked", {10'h000, irq}, 11'h000);
        // sleep code set a cycle before the clear, so the next round surely sleeps
        @(posedge ref_clk_i) sleep <= 3'h1;
        @(posedge ref_clk_i) rclr <= 1'b1;
        @(posedge ref_clk_i) rclr <= 1'b0;
        wait_hi(1, 4000);
        i = starts_seen;
        repeat (300) @(negedge ref_clk_i);
        check("starts in sleep", 11'(starts_seen), 11'(i));
        check("busy in sleep", {10'h000, busy}, 11'h001);
        @(posedge ref_clk_i) start <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check("busy after stop", {10'h000, busy}, 11'h000);
        check("pll released", {10'h000, pll_req}, 11'h000);
        check("flag kept", {10'h000, rnd}, 11'h001);
        final_report();
    end
endmodule : test_adc_channel_sequencer
